// File: common/mac_fc_pkg.sv
package mac_fc_pkg;

  localparam int OCTET_W = 8;
  localparam int ADDR_W  = 64;
  localparam int PAN_W   = 16;
  localparam int FCF_W   = 16;
  localparam int LEN_W   = 8;

  // frame control field layout
  localparam int FC_TYPE_LSB  = 0;
  localparam int FC_SEC_BIT   = 3;
  localparam int FC_PEND_BIT  = 4;
  localparam int FC_ACK_BIT   = 5;
  localparam int FC_PANC_BIT  = 6;
  localparam int FC_DMODE_LSB = 10;
  localparam int FC_VER_LSB   = 12;
  localparam int FC_SMODE_LSB = 14;

  typedef logic [2:0] ftype_t;
  typedef logic [1:0] amode_t;

  localparam ftype_t TYPE_BEACON = 3'h0;
  localparam ftype_t TYPE_DATA   = 3'h1;
  localparam ftype_t TYPE_ACK    = 3'h2;
  localparam ftype_t TYPE_CMD    = 3'h3;

  localparam amode_t MODE_NONE  = 2'h0;
  localparam amode_t MODE_SHORT = 2'h2;
  localparam amode_t MODE_EXT   = 2'h3;

  localparam logic [2:0] RSV_VALUE = 3'h0;

  localparam logic [3:0] LEN_CTL   = 4'h2;
  localparam logic [3:0] LEN_SEQ   = 4'h1;
  localparam logic [3:0] LEN_PAN   = 4'h2;
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] LEN_EXT   = 4'h8;
  localparam logic [3:0] LEN_FCS   = 4'h2;
  localparam logic [3:0] LEN_NONE  = 4'h0;

  // ITU x^16+x^12+x^5+1, bit-reversed because octets go lsb first
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // control + sequence + check sequence
  localparam logic [LEN_W-1:0] MIN_MPDU = 8'h05;

  typedef enum logic [3:0] {
    FIdle = 4'h0,
    FCtl  = 4'h1,
    FSeq  = 4'h3,
    FDPan = 4'h2,
    FDAdr = 4'h6,
    FSPan = 4'h7,
    FSAdr = 4'h5,
    FBody = 4'h4,
    FFcs  = 4'hc,
    FSkip = 4'hd
  } field_t;

  function automatic logic [3:0] addr_len(amode_t m);
    unique case (m)
      MODE_SHORT: return LEN_SHORT;
      MODE_EXT:   return LEN_EXT;
      default:    return LEN_NONE;
    endcase
  endfunction

  // dp: destination present, spp: source pan present, sp: source present
  function automatic field_t after(field_t f, logic dp, logic spp,
                                   logic sp, logic body);
    field_t tail;
    tail = body ? FBody : FFcs;
    unique case (f)
      FCtl:    return FSeq;
      FSeq:    return dp ? FDPan : spp ? FSPan : sp ? FSAdr : tail;
      FDPan:   return FDAdr;
      FDAdr:   return spp ? FSPan : sp ? FSAdr : tail;
      FSPan:   return FSAdr;
      FSAdr:   return tail;
      FBody:   return FFcs;
      default: return FIdle;
    endcase
  endfunction

  function automatic logic [15:0] crc_step(logic [15:0] c,
                                           logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

endpackage

// File: common/mac_phy_if.sv
`timescale 1ns/1ps
interface mac_phy_if (
  input wire logic mclk,
  input wire logic srst
);
  logic       txValid;
  logic       txReady;
  logic [7:0] txData;
  logic       txLast;
  logic       rxValid;
  logic       rxReady;
  logic [7:0] rxData;
  logic       rxLast;

  modport dev (
    input  mclk, srst,
    output txValid, txData, txLast,
    input  txReady,
    input  rxValid, rxData, rxLast,
    output rxReady
  );

  modport phy (
    input  mclk, srst,
    input  txValid, txData, txLast,
    output txReady,
    output rxValid, rxData, rxLast,
    input  rxReady
  );
endinterface

// File: hdl/mac_frame_codec.sv
// How it works
// - header, payload, footer sections in that order
// - control, sequence, check sequence always present
// - multi-octet fields go least significant octet first
// - control bits 0-2 carry frame type
// - security bit gates auxiliary security header
// - bit 4 flags further pending data
// - bit 5 requests an acknowledgment
// - no compression: PAN id precedes its address
// - compression: only destination PAN id sent
// - complete MPDUs pass to and from PHY
// - reserved bits 7-9 sent as zero
// - bits 10-11 select destination address mode
// - source PAN needs source mode, no compression
// - two-octet ITU CRC-16 closes every frame
`timescale 1ns/1ps
module octet_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             full;
  logic             empty;

  assign empty    = wrPtr_q == rdPtr_q;
  assign full     = (wrPtr_q[AW] != rdPtr_q[AW])
                 && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

module mac_frame_codec #(
  parameter int FIFO_DEPTH = 8
) (
  mac_phy_if.dev           link,
  input  wire logic        txStart,
  output logic             txBusy,
  input  wire logic [2:0]  txType,
  input  wire logic        txSecEn,
  input  wire logic        txPending,
  input  wire logic        txAckReq,
  input  wire logic        txPanComp,
  input  wire logic [1:0]  txDstMode,
  input  wire logic [1:0]  txVersion,
  input  wire logic [1:0]  txSrcMode,
  input  wire logic [7:0]  txSeq,
  input  wire logic [15:0] txDstPan,
  input  wire logic [63:0] txDstAddr,
  input  wire logic [15:0] txSrcPan,
  input  wire logic [63:0] txSrcAddr,
  input  wire logic [7:0]  txAuxLen,
  input  wire logic [7:0]  txPldLen,
  input  wire logic        bodyInValid,
  output logic             bodyInReady,
  input  wire logic [7:0]  bodyInData,
  input  wire logic [7:0]  rxAuxLen,
  output logic             rxDone,
  output logic             rxFcsOk,
  output logic             rxTruncated,
  output logic             rxUnsupported,
  output logic [15:0]      rxFcf,
  output logic [7:0]       rxSeq,
  output logic [15:0]      rxDstPan,
  output logic [63:0]      rxDstAddr,
  output logic [15:0]      rxSrcPan,
  output logic [63:0]      rxSrcAddr,
  output logic             rxBodyValid,
  output logic [7:0]       rxBodyData,
  output logic             rxBodyIsAux
);
  // ---------------- transmit ----------------
  mac_fc_pkg::field_t encSt_q;
  logic [15:0] encFcf_q;
  logic [7:0]  encSeq_q;
  logic [15:0] encDPan_q;
  logic [63:0] encDAdr_q;
  logic [15:0] encSPan_q;
  logic [63:0] encSAdr_q;
  logic [8:0]  bodyLeft_q;
  logic [3:0]  encCnt_q;
  logic [15:0] encCrc_q;
  logic [63:0] encVal;
  logic [3:0]  encLen;
  logic [7:0]  encOctet;
  logic        emit;
  logic        taken;
  logic        fifoInReady;
  logic        fDst;
  logic        fSrc;
  logic        fSPan;
  logic        fBody;
  logic        mclk;

  assign mclk  = link.mclk;
  // reserved mode 01 carries no field, so only 10 and 11 count
  assign fDst  = encFcf_q[mac_fc_pkg::FC_DMODE_LSB +: 2]
              >= mac_fc_pkg::MODE_SHORT;
  assign fSrc  = encFcf_q[mac_fc_pkg::FC_SMODE_LSB +: 2]
              >= mac_fc_pkg::MODE_SHORT;
  assign fSPan = fSrc && !encFcf_q[mac_fc_pkg::FC_PANC_BIT];
  assign fBody = bodyLeft_q != '0;

  always_comb begin
    encVal = '0;
    encLen = mac_fc_pkg::LEN_NONE;
    unique case (encSt_q)
      mac_fc_pkg::FCtl: begin
        encVal = {48'h0, encFcf_q};
        encLen = mac_fc_pkg::LEN_CTL;
      end
      mac_fc_pkg::FSeq: begin
        encVal = {56'h0, encSeq_q};
        encLen = mac_fc_pkg::LEN_SEQ;
      end
      mac_fc_pkg::FDPan: begin
        encVal = {48'h0, encDPan_q};
        encLen = mac_fc_pkg::LEN_PAN;
      end
      mac_fc_pkg::FDAdr: begin
        encVal = encDAdr_q;
        encLen = mac_fc_pkg::addr_len(
                 encFcf_q[mac_fc_pkg::FC_DMODE_LSB +: 2]);
      end
      mac_fc_pkg::FSPan: begin
        encVal = {48'h0, encSPan_q};
        encLen = mac_fc_pkg::LEN_PAN;
      end
      mac_fc_pkg::FSAdr: begin
        encVal = encSAdr_q;
        encLen = mac_fc_pkg::addr_len(
                 encFcf_q[mac_fc_pkg::FC_SMODE_LSB +: 2]);
      end
      mac_fc_pkg::FFcs: begin
        encVal = {48'h0, encCrc_q};
        encLen = mac_fc_pkg::LEN_FCS;
      end
      default: begin
        encVal = '0;
        encLen = mac_fc_pkg::LEN_NONE;
      end
    endcase
  end

  assign encOctet = (encSt_q == mac_fc_pkg::FBody) ? bodyInData
                  : encVal[encCnt_q[2:0]*8 +: 8];
  assign emit     = (encSt_q == mac_fc_pkg::FBody) ? bodyInValid
                  : (encSt_q != mac_fc_pkg::FIdle);
  assign taken    = emit && fifoInReady;
  // the fifo's ready stalls the encoder, body source included
  assign bodyInReady = (encSt_q == mac_fc_pkg::FBody) && fifoInReady;
  assign txBusy      = encSt_q != mac_fc_pkg::FIdle;

  always_ff @(posedge mclk) begin
    if (link.srst) begin
      encFcf_q   <= '0;
      encSeq_q   <= '0;
      encDPan_q  <= '0;
      encDAdr_q  <= '0;
      encSPan_q  <= '0;
      encSAdr_q  <= '0;
    end else if (txStart && !txBusy) begin
      encFcf_q <= {txSrcMode, txVersion, txDstMode,
                   mac_fc_pkg::RSV_VALUE,
                   txPanComp, txAckReq, txPending, txSecEn,
                   txType};
      encSeq_q  <= txSeq;
      encDPan_q <= txDstPan;
      encDAdr_q <= txDstAddr;
      encSPan_q <= txSrcPan;
      encSAdr_q <= txSrcAddr;
    end
  end

  always_ff @(posedge mclk) begin
    if (link.srst) begin
      encSt_q    <= mac_fc_pkg::FIdle;
      encCnt_q   <= '0;
      bodyLeft_q <= '0;
    end else if (txStart && !txBusy) begin
      encSt_q    <= mac_fc_pkg::FCtl;
      encCnt_q   <= '0;
      bodyLeft_q <= (txSecEn ? {1'b0, txAuxLen} : 9'h0)
                  + {1'b0, txPldLen};
    end else if (taken) begin
      if (encSt_q == mac_fc_pkg::FBody) begin
        bodyLeft_q <= bodyLeft_q - 1'b1;
        if (bodyLeft_q == 9'h1) begin
          encSt_q <= mac_fc_pkg::FFcs;
        end
      end else if (encCnt_q == encLen - 1'b1) begin
        encCnt_q <= '0;
        encSt_q  <= mac_fc_pkg::after(encSt_q, fDst, fSPan, fSrc, fBody);
      end else begin
        encCnt_q <= encCnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (link.srst || !txBusy) begin
      encCrc_q <= mac_fc_pkg::CRC_INIT;
    end else if (taken && encSt_q != mac_fc_pkg::FFcs) begin
      encCrc_q <= mac_fc_pkg::crc_step(encCrc_q, encOctet);
    end
  end

  // elastic store between the encoder and the link
  octet_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) txFifo (
    .mclk     (link.mclk),
    .srst     (link.srst),
    .inValid  (emit),
    .inReady  (fifoInReady),
    .inData   ({encSt_q == mac_fc_pkg::FFcs && encCnt_q != '0,
                encOctet}),
    .outValid (link.txValid),
    .outReady (link.txReady),
    .outData  ({link.txLast, link.txData})
  );

  // ---------------- receive ----------------
  mac_fc_pkg::field_t decSt_q;
  logic [3:0]  decCnt_q;
  logic [15:0] decCrc_q;
  logic [15:0] decCrcNext;
  logic [15:0] fcfNow;
  logic [3:0]  decLen;
  logic [7:0]  hold0_q;
  logic [7:0]  hold1_q;
  logic [1:0]  held_q;
  logic [7:0]  bodyIdx_q;
  logic        rDst;
  logic        rSrc;
  logic        rSPan;
  logic        fieldEnd;
  logic        octIn;

  assign link.rxReady = 1'b1;
  assign octIn   = link.rxValid;
  assign fcfNow  = {link.rxData, rxFcf[7:0]};
  assign rDst    = rxFcf[mac_fc_pkg::FC_DMODE_LSB +: 2]
                >= mac_fc_pkg::MODE_SHORT;
  assign rSrc    = rxFcf[mac_fc_pkg::FC_SMODE_LSB +: 2]
                >= mac_fc_pkg::MODE_SHORT;
  assign rSPan   = rSrc && !rxFcf[mac_fc_pkg::FC_PANC_BIT];
  assign decCrcNext = mac_fc_pkg::crc_step(decCrc_q, link.rxData);

  always_comb begin
    unique case (decSt_q)
      mac_fc_pkg::FCtl:  decLen = mac_fc_pkg::LEN_CTL;
      mac_fc_pkg::FSeq:  decLen = mac_fc_pkg::LEN_SEQ;
      mac_fc_pkg::FDAdr: decLen = mac_fc_pkg::addr_len(
                         rxFcf[mac_fc_pkg::FC_DMODE_LSB +: 2]);
      mac_fc_pkg::FSAdr: decLen = mac_fc_pkg::addr_len(
                         rxFcf[mac_fc_pkg::FC_SMODE_LSB +: 2]);
      default:           decLen = mac_fc_pkg::LEN_PAN;
    endcase
  end
  assign fieldEnd = decCnt_q == decLen - 1'b1;

  always_ff @(posedge mclk) begin
    if (link.srst) begin
      decSt_q       <= mac_fc_pkg::FCtl;
      decCnt_q      <= '0;
      rxDone        <= 1'b0;
      rxFcsOk       <= 1'b0;
      rxTruncated   <= 1'b0;
      rxUnsupported <= 1'b0;
    end else begin
      rxDone <= octIn && link.rxLast;
      if (octIn && link.rxLast) begin
        decSt_q       <= mac_fc_pkg::FCtl;
        decCnt_q      <= '0;
        // an empty body still has its first check octet held here
        rxFcsOk       <= decSt_q == mac_fc_pkg::FBody && held_q != 2'h0
                      && decCrcNext == mac_fc_pkg::CRC_GOOD;
        rxTruncated   <= decSt_q != mac_fc_pkg::FBody
                      && decSt_q != mac_fc_pkg::FSkip;
        rxUnsupported <= decSt_q == mac_fc_pkg::FSkip;
      end else if (octIn && decSt_q == mac_fc_pkg::FCtl && fieldEnd
                   && fcfNow[mac_fc_pkg::FC_TYPE_LSB + 2]) begin
        decSt_q <= mac_fc_pkg::FSkip;
      end else if (octIn && decSt_q != mac_fc_pkg::FBody
                   && decSt_q != mac_fc_pkg::FSkip) begin
        if (fieldEnd) begin
          decCnt_q <= '0;
          decSt_q  <= mac_fc_pkg::after(decSt_q, rDst, rSPan, rSrc,
                                        1'b1);
        end else begin
          decCnt_q <= decCnt_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (link.srst) begin
      decCrc_q <= mac_fc_pkg::CRC_INIT;
    end else if (octIn) begin
      decCrc_q <= link.rxLast ? mac_fc_pkg::CRC_INIT : decCrcNext;
    end
  end

  // header fields, lsb octet first
  always_ff @(posedge mclk) begin
    if (link.srst) begin
      rxFcf     <= '0;
      rxSeq     <= '0;
      rxDstPan  <= '0;
      rxDstAddr <= '0;
      rxSrcPan  <= '0;
      rxSrcAddr <= '0;
    end else if (octIn) begin
      unique case (decSt_q)
        mac_fc_pkg::FCtl: begin
          rxFcf[decCnt_q[0]*8 +: 8] <= link.rxData;
          if (decCnt_q == '0) begin
            rxDstAddr <= '0;
            rxSrcAddr <= '0;
          end
        end
        mac_fc_pkg::FSeq:  rxSeq <= link.rxData;
        mac_fc_pkg::FDPan: rxDstPan[decCnt_q[0]*8 +: 8] <= link.rxData;
        mac_fc_pkg::FDAdr: rxDstAddr[decCnt_q[2:0]*8 +: 8] <= link.rxData;
        mac_fc_pkg::FSPan: rxSrcPan[decCnt_q[0]*8 +: 8] <= link.rxData;
        mac_fc_pkg::FSAdr: rxSrcAddr[decCnt_q[2:0]*8 +: 8] <= link.rxData;
        default: begin
        end
      endcase
    end
  end

  // two octets held back: the last two of a frame are its check sequence
  always_ff @(posedge mclk) begin
    if (link.srst) begin
      hold0_q     <= '0;
      hold1_q     <= '0;
      held_q      <= '0;
      bodyIdx_q   <= '0;
      rxBodyValid <= 1'b0;
      rxBodyData  <= '0;
      rxBodyIsAux <= 1'b0;
    end else begin
      rxBodyValid <= 1'b0;
      if (octIn && decSt_q == mac_fc_pkg::FBody) begin
        hold0_q <= link.rxData;
        hold1_q <= hold0_q;
        if (held_q == 2'h2) begin
          rxBodyValid <= 1'b1;
          rxBodyData  <= hold1_q;
          rxBodyIsAux <= rxFcf[mac_fc_pkg::FC_SEC_BIT]
                      && bodyIdx_q < rxAuxLen;
          bodyIdx_q   <= bodyIdx_q + 1'b1;
        end else begin
          held_q <= held_q + 1'b1;
        end
        if (link.rxLast) begin
          held_q    <= '0;
          bodyIdx_q <= '0;
        end
      end else if (octIn && link.rxLast) begin
        held_q    <= '0;
        bodyIdx_q <= '0;
      end
    end
  end
endmodule

// File: hdl/phy_data_port.sv
`timescale 1ns/1ps
module phy_data_port (
  mac_phy_if.phy          link,
  output logic            phyTxValid,
  input  wire logic       phyTxReady,
  output logic [7:0]      phyTxData,
  output logic            phyTxLast,
  output logic            txFrameDone,
  output logic            txRunt,
  output logic [7:0]      txOctets,
  input  wire logic       phyRxValid,
  output logic            phyRxReady,
  input  wire logic [7:0] phyRxData,
  input  wire logic       phyRxLast
);
  logic [7:0] txCnt_q;
  logic       txTake;
  logic       rxValid_q;
  logic [7:0] rxData_q;
  logic       rxLast_q;

  // one register stage toward the radio
  assign link.txReady = !phyTxValid || phyTxReady;
  assign txTake       = link.txValid && link.txReady;

  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      phyTxValid <= 1'b0;
      phyTxData  <= '0;
      phyTxLast  <= 1'b0;
    end else if (link.txReady) begin
      phyTxValid <= link.txValid;
      phyTxData  <= link.txData;
      phyTxLast  <= link.txLast;
    end
  end

  // whole MPDU length; anything under the fixed fields is a runt
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      txCnt_q     <= '0;
      txOctets    <= '0;
      txFrameDone <= 1'b0;
      txRunt      <= 1'b0;
    end else begin
      txFrameDone <= txTake && link.txLast;
      txRunt      <= txTake && link.txLast
                  && (txCnt_q + 8'h1) < mac_fc_pkg::MIN_MPDU;
      if (txTake) begin
        txCnt_q <= link.txLast ? 8'h0 : txCnt_q + 8'h1;
        if (link.txLast) begin
          txOctets <= txCnt_q + 8'h1;
        end
      end
    end
  end

  // received octets in order, lsb octet of each field first
  assign phyRxReady = link.rxReady;
  always_ff @(posedge link.mclk) begin
    if (link.srst) begin
      rxValid_q <= 1'b0;
      rxData_q  <= '0;
      rxLast_q  <= 1'b0;
    end else if (link.rxReady || !rxValid_q) begin
      rxValid_q <= phyRxValid;
      rxData_q  <= phyRxData;
      rxLast_q  <= phyRxLast;
    end
  end
  assign link.rxValid = rxValid_q;
  assign link.rxData  = rxData_q;
  assign link.rxLast  = rxLast_q;
endmodule

// File: testbench/mac_phy_if_assertions.sv
`timescale 1ns/1ps
module mac_phy_if_assertions (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic [7:0] txData,
  input wire logic       txLast,
  input wire logic       rxValid,
  input wire logic       rxReady,
  input wire logic [7:0] rxData,
  input wire logic       rxLast
);
  logic [7:0]  txCnt_q;
  logic [7:0]  rxCnt_q;
  logic [15:0] txFc_q;
  logic        txGo;
  logic        rxGo;
  assign txGo = txValid && txReady;
  assign rxGo = rxValid && rxReady;
  always_ff @(posedge mclk) begin
    if (srst || (txGo && txLast)) begin
      txCnt_q <= 8'h00;
    end else if (txGo) begin
      txCnt_q <= txCnt_q + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst || (rxGo && rxLast)) begin
      rxCnt_q <= 8'h00;
    end else if (rxGo) begin
      rxCnt_q <= rxCnt_q + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (txGo && txCnt_q == 8'h00) begin
      txFc_q[7:0] <= txData;
    end
    if (txGo && txCnt_q == 8'h01) begin
      txFc_q[15:8] <= txData;
    end
  end
  // shortest frame the control field allows; aux length not visible here
  function automatic logic [7:0] min_len(logic [15:0] f);
    return 8'h05 + (f[11] ? (f[10] ? 8'h0a : 8'h04) : 8'h00)
         + (f[15] ? (f[14] ? 8'h08 : 8'h02) : 8'h00)
         + ((f[15] && !f[6]) ? 8'h02 : 8'h00);
  endfunction
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_tx_valid_holds: assert property (
    txValid && !txReady |=> txValid) else $error("tx valid dropped");
  a_tx_octet_holds: assert property (
    txValid && !txReady |=> $stable(txData) && $stable(txLast))
    else $error("tx octet changed while stalled");
  a_rx_never_stalls: assert property (
    rxReady) else $error("rx ready low");
  a_rsv_low_zero: assert property (
    txGo && txCnt_q == 8'h00 |-> !txData[7])
    else $error("reserved bit 7 set");
  a_rsv_high_zero: assert property (
    txGo && txCnt_q == 8'h01 |-> txData[1:0] == 2'h0)
    else $error("reserved bits 8-9 set");
  a_tx_min_frame: assert property (
    txGo && txLast |-> txCnt_q >= 8'h04) else $error("tx frame short");
  a_tx_hdr_fields: assert property (
    txGo && txLast && txCnt_q > 8'h01 |-> txCnt_q + 8'h01 >= min_len(txFc_q))
    else $error("tx frame lacks header fields");
  a_rx_min_frame: assert property (
    rxGo && rxLast |-> rxCnt_q >= 8'h04) else $error("rx frame short");
  c_ack_frame: cover property (txGo && txLast && txCnt_q == 8'h04);
  c_tx_stall: cover property (txValid && !txReady);
  c_long_frame: cover property (txGo && txLast && txCnt_q > 8'h14);
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        mclk, srst, txStart, txBusy, txSecEn, txPending, txAckReq;
  logic        txPanComp, bodyInValid, bodyInReady, rxDone, rxFcsOk;
  logic        rxTruncated, rxUnsupported, rxBodyValid, rxBodyIsAux;
  logic        phyTxValid, phyTxReady, phyTxLast, txFrameDone, txRunt;
  logic        phyRxValid, phyRxReady, phyRxLast, bPend, keep, slow, seen;
  logic [2:0]  txType;
  logic [1:0]  txDstMode, txVersion, txSrcMode;
  logic [7:0]  txSeq, txAuxLen, txPldLen, bodyInData, rxAuxLen, rxSeq;
  logic [7:0]  rxBodyData, phyTxData, txOctets, phyRxData;
  logic [15:0] txDstPan, txSrcPan, rxFcf, rxDstPan, rxSrcPan;
  logic [63:0] txDstAddr, txSrcAddr, rxDstAddr, rxSrcAddr;
  logic [31:0] rnd;
  logic [7:0]  body[$], got[$], exp[$];
  logic [8:0]  gotBody[$];
  int          bad_count, checks, bIdx, flip, frames;
  mac_phy_if i_mac_phy_if (.mclk(mclk), .srst(srst));
  mac_frame_codec #(.FIFO_DEPTH(8)) i_mac_frame_codec (
    .link(i_mac_phy_if), .txStart, .txBusy, .txType, .txSecEn, .txPending,
    .txAckReq, .txPanComp, .txDstMode, .txVersion, .txSrcMode, .txSeq,
    .txDstPan, .txDstAddr, .txSrcPan, .txSrcAddr, .txAuxLen, .txPldLen,
    .bodyInValid, .bodyInReady, .bodyInData, .rxAuxLen, .rxDone, .rxFcsOk,
    .rxTruncated, .rxUnsupported, .rxFcf, .rxSeq, .rxDstPan, .rxDstAddr,
    .rxSrcPan, .rxSrcAddr, .rxBodyValid, .rxBodyData, .rxBodyIsAux);
  phy_data_port i_phy_data_port (
    .link(i_mac_phy_if), .phyTxValid, .phyTxReady, .phyTxData, .phyTxLast,
    .txFrameDone, .txRunt, .txOctets, .phyRxValid, .phyRxReady, .phyRxData,
    .phyRxLast);
  mac_phy_if_assertions i_mac_phy_if_assertions (
    .mclk(mclk), .srst(srst), .txValid(i_mac_phy_if.txValid),
    .txReady(i_mac_phy_if.txReady), .txData(i_mac_phy_if.txData),
    .txLast(i_mac_phy_if.txLast), .rxValid(i_mac_phy_if.rxValid),
    .rxReady(i_mac_phy_if.rxReady), .rxData(i_mac_phy_if.rxData),
    .rxLast(i_mac_phy_if.rxLast));
  function automatic logic [31:0] nx();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  task automatic cmp(input string nm, input logic [63:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // body source holds each octet until taken; phy output loops back to rx
  always @(negedge mclk) begin
    void'(nx());
    keep = bodyInValid && !bPend;
    if (bPend) bIdx++;
    bodyInValid = bIdx < body.size() && (keep || rnd[0]);
    bodyInData = bIdx < body.size() ? body[bIdx] : ~bodyInData;
    bPend = bodyInValid && bodyInReady === 1'b1;
    phyTxReady = slow ? rnd[4:1] == 4'h0 : rnd[1] | rnd[2];
    phyRxValid = phyTxValid === 1'b1 && phyTxReady;
    if (phyRxValid) begin
      got.push_back(phyTxData);
      phyRxData = phyTxData ^ {7'h0, got.size() == flip};
      phyRxLast = phyTxLast;
    end else phyRxData = ~phyRxData;
    if (rxBodyValid === 1'b1) gotBody.push_back({rxBodyIsAux, rxBodyData});
    if (rxDone === 1'b1) seen = 1'b1;
    if (txFrameDone === 1'b1) frames += txRunt === 1'b0 ? 1 : 100;
  end
  task automatic send(input logic [2:0] ty, input logic sc, pn, ak, pc,
                      input logic [1:0] dm, sm, input logic [7:0] pl,
                      input logic bad);
    logic [15:0] fc, c;
    int n;
    @(negedge mclk);
    #1;
    {txType, txSecEn, txPending, txAckReq, txPanComp} = {ty, sc, pn, ak, pc};
    {txDstMode, txSrcMode, txPldLen, txVersion} = {dm, sm, pl, 1'b0, rnd[5]};
    {txSeq, txDstPan, txSrcPan} = {nx(), 8'h00};
    txDstAddr = {nx(), nx()};
    txSrcAddr = {nx(), nx()};
    txAuxLen = sc ? 8'h02 : 8'h00;
    fc = {sm, txVersion, dm, 3'h0, pc, ak, pn, sc, ty};
    exp = {fc[7:0], fc[15:8], txSeq};
    for (n = 0; dm[1] && n < 2; n++) exp.push_back(txDstPan[8*n +: 8]);
    for (n = 0; dm[1] && n < (dm[0] ? 8 : 2); n++)
      exp.push_back(txDstAddr[8*n +: 8]);
    for (n = 0; sm[1] && !pc && n < 2; n++) exp.push_back(txSrcPan[8*n +: 8]);
    for (n = 0; sm[1] && n < (sm[0] ? 8 : 2); n++)
      exp.push_back(txSrcAddr[8*n +: 8]);
    body = {};
    for (n = 0; n < txAuxLen + pl; n++) body.push_back(nx());
    exp = {exp, body};
    c = 16'h0000;
    foreach (exp[i]) for (n = 0; n < 8; n++)
      c = (c[0] ^ exp[i][n]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    exp = {exp, c[7:0], c[15:8]};
    got = {};
    gotBody = {};
    {bIdx, seen, txStart} = {32'h0, 1'b0, 1'b1};
    flip = bad ? exp.size() - 2 : 0;
    @(negedge mclk);
    #1;
    txStart = 1'b0;
    cmp("busy", 1'b1, txBusy);
    for (n = 0; !seen && n < 3000; n++) @(negedge mclk);
    #1;
    cmp("frame seen", 1'b1, seen);
    cmp("rx ready", 1'b1, phyRxReady);
    cmp("wire length", exp.size(), got.size());
    cmp("tx octets", exp.size(), txOctets);
    foreach (exp[i]) if (i < got.size())
      cmp("wire octet", exp[i], got[i]);
    cmp("unsupported", ty[2], rxUnsupported);
    cmp("fcs ok", !ty[2] && !bad, rxFcsOk);
    if (ty[2]) return;
    cmp("truncated", 1'b0, rxTruncated);
    cmp("fcf", fc, rxFcf);
    cmp("seq", txSeq, rxSeq);
    if (dm[1]) cmp("dst pan", txDstPan, rxDstPan);
    if (dm[1]) cmp("dst addr", dm[0] ? txDstAddr : txDstAddr[15:0],
                   dm[0] ? rxDstAddr : rxDstAddr[15:0]);
    if (sm[1] && !pc) cmp("src pan", txSrcPan, rxSrcPan);
    if (sm[1]) cmp("src addr", sm[0] ? txSrcAddr : txSrcAddr[15:0],
                   sm[0] ? rxSrcAddr : rxSrcAddr[15:0]);
    if (bad) return;
    cmp("body length", body.size(), gotBody.size());
    foreach (body[i]) if (i < gotBody.size())
      cmp("body", {i < txAuxLen, body[i]}, gotBody[i]);
  endtask
  initial begin
    {srst, txStart, bodyInValid, bodyInData, phyRxData} = {3'h4, 16'h0};
    {phyTxReady, phyRxValid, phyRxLast, bPend, slow, seen} = 6'h0;
    {rxAuxLen, rnd, bIdx, flip} = {8'h02, 32'h3ec12e6f, 64'h0};
    {bad_count, checks, frames} = 96'h0;
    {txType, txSecEn, txPending, txAckReq, txPanComp} = 7'h0;
    {txDstMode, txSrcMode, txPldLen, txVersion, txSeq} = 22'h0;
    {txAuxLen, txDstPan, txSrcPan, txDstAddr, txSrcAddr} = 168'h0;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    send(mac_fc_pkg::TYPE_ACK, 0, 0, 0, 0, 2'h0, 2'h0, 8'h00, 0);
    send(mac_fc_pkg::TYPE_DATA, 1, 1, 1, 1, 2'h3, 2'h3, 8'h07, 0);
    send(mac_fc_pkg::TYPE_CMD, 0, 0, 1, 0, 2'h0, 2'h2, 8'h03, 0);
    send(mac_fc_pkg::TYPE_BEACON, 0, 1, 0, 1, 2'h0, 2'h3, 8'h02, 0);
    send(mac_fc_pkg::TYPE_DATA, 0, 0, 0, 0, 2'h2, 2'h2, 8'h04, 1);
    send(3'h5, 0, 0, 0, 0, 2'h2, 2'h0, 8'h01, 0);
    slow = 1'b1;
    send(mac_fc_pkg::TYPE_DATA, 1, 0, 1, 0, 2'h3, 2'h2, 8'h0c, 0);
    slow = 1'b0;
    for (int k = 0; k < 16; k++) begin
      void'(nx());
      send(rnd[1:0] == 2'h2 ? 3'h1 : {1'b0, rnd[1:0]}, rnd[2], rnd[3],
           rnd[4], rnd[5], rnd[7:6], rnd[9:8], {4'h0, rnd[13:10]}, 0);
    end
    cmp("tx frames", 23, frames);
    test_done();
  end
  initial begin
    #200us;
    bad_count++;
    test_done();
  end
endmodule
